// ---- pkg/oas_pkg.sv ----
// constants and carrier types for the operand decode / skip timing block
// assumes a 12-bit data-memory address made of a 4-bit bank and 8-bit offset
package oas_pkg;

   // data memory banks
   localparam logic [3:0] OAS_BANK_0 = 4'h0;
   localparam logic [3:0] OAS_BANK_4 = 4'h4;
   localparam logic [3:0] OAS_BANK_15 = 4'hF;

   // fixed i/o areas and program-memory limits
   localparam logic [11:0] OAS_FMEM_LO0 = 12'hFB0;
   localparam logic [11:0] OAS_FMEM_HI0 = 12'hFBF;
   localparam logic [11:0] OAS_FMEM_LO1 = 12'hFF0;
   localparam logic [11:0] OAS_FMEM_HI1 = 12'hFFF;
   localparam logic [11:0] OAS_PMEM_LO = 12'hFC0;
   localparam logic [11:0] OAS_PMEM_HI = 12'hFFF;
   localparam logic [11:0] OAS_TADDR_LO = 12'h020;
   localparam logic [11:0] OAS_TADDR_HI = 12'h07F;
   localparam logic [11:0] OAS_FADDR_HI = 12'h7FF;

   // relative branch reach, in locations from the current pc
   localparam logic signed [12:0] OAS_REL_BACK_MIN = -13'sh00F;
   localparam logic signed [12:0] OAS_REL_BACK_MAX = -13'sh001;
   localparam logic signed [12:0] OAS_REL_FWD_MIN = 13'sh002;
   localparam logic signed [12:0] OAS_REL_FWD_MAX = 13'sh010;

   // register codes: X, A, B, C, D, E, H, L
   localparam logic [2:0] OAS_REG_A = 3'h1;
   // pair codes: XA, BC, DE, HL; bit 2 picks the alternate bank
   localparam logic [1:0] OAS_RP_XA = 2'h0;
   localparam logic [1:0] OAS_RP_BC = 2'h1;
   localparam logic [1:0] OAS_RP_DE = 2'h2;

   // extra machine cycles of a skip
   localparam logic [1:0] OAS_SKIP_NONE = 2'h0;
   localparam logic [1:0] OAS_SKIP_SHORT = 2'h1;
   localparam logic [1:0] OAS_SKIP_LONG = 2'h2;

   // machine cycle settings; setting 0 is the reset value
   localparam logic [1:0] OAS_CLK_CTRL_RESET = 2'h0;
   localparam int OAS_MC_DIV_0 = 8;
   localparam int OAS_MC_DIV_1 = 4;
   localparam int OAS_MC_DIV_2 = 2;
   localparam int OAS_MC_DIV_3 = 1;

   typedef enum logic [4:0] {
      OAS_OC_REG = 5'h00, OAS_OC_REG1 = 5'h01, OAS_OC_RP = 5'h02,
      OAS_OC_RP1 = 5'h03, OAS_OC_RP2 = 5'h04, OAS_OC_RPX = 5'h05,
      OAS_OC_RPX1 = 5'h06, OAS_OC_RPA = 5'h07, OAS_OC_RIP = 5'h08,
      OAS_OC_N4 = 5'h09, OAS_OC_N8 = 5'h0A, OAS_OC_MEM = 5'h0B,
      OAS_OC_MEM8 = 5'h0C, OAS_OC_BIT = 5'h0D, OAS_OC_FMEM = 5'h0E,
      OAS_OC_PMEM = 5'h0F, OAS_OC_TADDR = 5'h10, OAS_OC_REL = 5'h11,
      OAS_OC_CADDR = 5'h12, OAS_OC_FADDR = 5'h13
   } oas_opclass_type;

   typedef enum logic [2:0] {
      OAS_PA_HL = 3'h0, OAS_PA_HL_INC = 3'h1, OAS_PA_HL_DEC = 3'h2,
      OAS_PA_DE = 3'h3, OAS_PA_DL = 3'h4
   } oas_rpa_type;

   typedef enum logic [2:0] {
      OAS_SO_OTHER = 3'h0, OAS_SO_BR_ABS = 3'h1,
      OAS_SO_BRANCH_ABS_ANY = 3'h2, OAS_SO_CALL_ABS = 3'h3,
      OAS_SO_CALL_ABS_ANY = 3'h4
   } oas_skipop_type;

   typedef struct packed {
      oas_opclass_type opclass;
      logic [11:0] operand;
      logic [11:0] pc;
   } oas_req_type;

   typedef struct packed {
      logic [7:0] hl;
      logic [7:0] de;
      logic [7:0] dl;
   } oas_ptr_type;

   typedef struct packed {
      logic unsupported;
      logic [3:0] bank;
      logic [11:0] addr;
      logic [2:0] reg_sel;
      logic alt_bank;
      logic [7:0] imm;
      logic [1:0] bit_sel;
      logic ptr_inc;
      logic ptr_dec;
   } oas_dec_type;

endpackage

// ---- src/oas_decoder.sv ----
// operand decode, data-memory bank resolution and skip cycle accounting
// assumes requests, pointers and bank flags come from core logic on clk_sys_in
`timescale 1ns/1ps
// What this block does
// - registers: A plus seven others; restricted class excludes A
// - pair classes: four with XA, three without, two, plus alternates
// - indirect: HL, HL+, HL-, DE, DL; restricted class only DE, DL
// - short immediates are 4 bits, long immediates 8 bits
// - direct address is 8 bits; bit number is a 2-bit field
// - bit i/o in FB0-FBF or FF0-FFF; pointer-bit i/o in FC0-FFF
// - table vector address lies in 20-7F and is even
// - bank enable clear: direct 00-7F go to bank 0, 80-FF to bank 15
// - bank enable set: direct bank is select; HL bank is enable AND select
// - DE and DL accesses always use bank 0
// - bit and pointer-bit i/o always use bank 15
// - relative target reaches pc-15 to pc-1 or pc+2 to pc+16
// - page jump target is 12 bits; short call 11 bits, 000-7FF
// - skip costs 0, 1 or 2 extra cycles by skipped length
// - only the four absolute branches and calls count as 3-byte
// - one machine cycle is one period of the selected cpu clock
module oas_decoder import oas_pkg::*; #(
   parameter int MC_DIV_0 = OAS_MC_DIV_0,
   parameter int MC_DIV_1 = OAS_MC_DIV_1,
   parameter int MC_DIV_2 = OAS_MC_DIV_2,
   parameter int MC_DIV_3 = OAS_MC_DIV_3
) (
   // clock, reset, enable
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic ce_in,
   // configuration
   input wire logic [1:0] cpu_clock_ctrl_in,
   input wire logic bank_enable_flag_in,
   input wire logic [3:0] bank_select_reg_in,
   // decode request
   input wire logic req_valid_in,
   input wire oas_req_type req_in,
   input wire oas_ptr_type ptr_in,
   // skip report
   input wire logic skip_valid_in,
   input wire logic skip_taken_in,
   input wire oas_skipop_type skipped_op_in,
   // decode result
   output logic dec_valid_out,
   output oas_dec_type dec_out,
   // timing
   output logic mc_tick_out,
   output logic exec_suppress_out,
   output logic [1:0] skip_extra_out
);

   typedef enum logic [1:0] {
      OAS_SK_IDLE = 2'b01,
      OAS_SK_RUN = 2'b10
   } oas_skstate_type;

   oas_skstate_type sk_state;
   oas_skstate_type next_sk_state;
   logic [1:0] sk_cnt;
   logic [1:0] next_sk_cnt;
   logic [1:0] next_skip_extra;
   logic next_suppress;
   logic next_dec_valid;
   oas_dec_type next_dec;
   logic accept;
   logic skip_go;
   logic long_skip;

   oas_mc_timer #(
      .DIV_0(MC_DIV_0),
      .DIV_1(MC_DIV_1),
      .DIV_2(MC_DIV_2),
      .DIV_3(MC_DIV_3)
   ) u_timer (
      .clk_sys_in(clk_sys_in),
      .rst_in(rst_in),
      .ce_in(ce_in),
      .cpu_clock_ctrl_in(cpu_clock_ctrl_in),
      .mc_tick_out(mc_tick_out)
   );

   function automatic logic in_range(input logic [11:0] v,
                                     input logic [11:0] lo,
                                     input logic [11:0] hi);
      in_range = (v >= lo) && (v <= hi);
   endfunction

   function automatic logic bank_legal(input logic [3:0] b);
      bank_legal = (b == OAS_BANK_0) || (b == OAS_BANK_4) ||
                   (b == OAS_BANK_15);
   endfunction

   function automatic logic rel_ok(input logic [11:0] pc,
                                   input logic [11:0] tgt);
      logic signed [12:0] d;
      d = $signed({1'b0, tgt}) - $signed({1'b0, pc});
      rel_ok = ((d >= OAS_REL_BACK_MIN) && (d <= OAS_REL_BACK_MAX)) ||
               ((d >= OAS_REL_FWD_MIN) && (d <= OAS_REL_FWD_MAX));
   endfunction

   // decode only in a machine cycle that is not being skipped
   assign accept = ce_in && mc_tick_out && req_valid_in &&
                   (sk_state == OAS_SK_IDLE);
   assign skip_go = ce_in && mc_tick_out && skip_valid_in &&
                    (sk_state == OAS_SK_IDLE);
   assign long_skip = (skipped_op_in == OAS_SO_BR_ABS) ||
                      (skipped_op_in == OAS_SO_BRANCH_ABS_ANY) ||
                      (skipped_op_in == OAS_SO_CALL_ABS) ||
                      (skipped_op_in == OAS_SO_CALL_ABS_ANY);

   always_comb begin
      logic [11:0] op;
      logic [3:0] hl_bank;
      op = req_in.operand;
      hl_bank = {4{bank_enable_flag_in}} & bank_select_reg_in;
      next_dec_valid = ce_in ? accept : dec_valid_out;
      next_dec = dec_out;
      if (accept) begin
         next_dec = '0;
         case (req_in.opclass)
            OAS_OC_REG, OAS_OC_REG1: begin
               next_dec.reg_sel = op[2:0];
               next_dec.unsupported = (op[11:3] != 9'h000) ||
                  ((req_in.opclass == OAS_OC_REG1) &&
                   (op[2:0] == OAS_REG_A));
            end
            OAS_OC_RP, OAS_OC_RP1, OAS_OC_RP2: begin
               next_dec.reg_sel = {1'b0, op[1:0]};
               case (req_in.opclass)
                  OAS_OC_RP1:
                     next_dec.unsupported = (op[1:0] == OAS_RP_XA);
                  OAS_OC_RP2:
                     next_dec.unsupported = (op[1:0] != OAS_RP_BC) &&
                                            (op[1:0] != OAS_RP_DE);
                  default:
                     next_dec.unsupported = 1'b0;
               endcase
               if (op[11:2] != 10'h000) begin
                  next_dec.unsupported = 1'b1;
               end
            end
            OAS_OC_RPX, OAS_OC_RPX1: begin
               next_dec.reg_sel = {1'b0, op[1:0]};
               next_dec.alt_bank = op[2];
               next_dec.unsupported = (op[11:3] != 9'h000) ||
                  ((req_in.opclass == OAS_OC_RPX1) &&
                   (op[2:0] == {1'b0, OAS_RP_XA}));
            end
            OAS_OC_RPA, OAS_OC_RIP: begin
               next_dec.unsupported = (op[11:3] != 9'h000) ||
                  (op[2:0] > OAS_PA_DL) ||
                  ((req_in.opclass == OAS_OC_RIP) &&
                   (op[2:0] < OAS_PA_DE));
               case (op[2:0])
                  OAS_PA_DE: begin
                     next_dec.addr = {OAS_BANK_0, ptr_in.de};
                  end
                  OAS_PA_DL: begin
                     next_dec.addr = {OAS_BANK_0, ptr_in.dl};
                  end
                  default: begin
                     next_dec.bank = hl_bank;
                     next_dec.addr = {hl_bank, ptr_in.hl};
                     next_dec.ptr_inc = (op[2:0] == OAS_PA_HL_INC);
                     next_dec.ptr_dec = (op[2:0] == OAS_PA_HL_DEC);
                     if (!bank_legal(hl_bank)) begin
                        next_dec.unsupported = 1'b1;
                     end
                  end
               endcase
            end
            OAS_OC_N4: begin
               next_dec.imm = {4'h0, op[3:0]};
               next_dec.unsupported = (op[11:4] != 8'h00);
            end
            OAS_OC_N8: begin
               next_dec.imm = op[7:0];
               next_dec.unsupported = (op[11:8] != 4'h0);
            end
            OAS_OC_MEM, OAS_OC_MEM8: begin
               if (bank_enable_flag_in) begin
                  next_dec.bank = bank_select_reg_in;
               end else begin
                  next_dec.bank = op[7] ? OAS_BANK_15 : OAS_BANK_0;
               end
               next_dec.addr = {next_dec.bank, op[7:0]};
               // odd address on an 8-bit transfer is a program error
               next_dec.unsupported = (op[11:8] != 4'h0) ||
                  !bank_legal(next_dec.bank) ||
                  ((req_in.opclass == OAS_OC_MEM8) && op[0]);
            end
            OAS_OC_BIT: begin
               next_dec.bit_sel = op[1:0];
               next_dec.unsupported = (op[11:2] != 10'h000);
            end
            OAS_OC_FMEM: begin
               next_dec.bank = OAS_BANK_15;
               next_dec.addr = op;
               next_dec.unsupported =
                  !(in_range(op, OAS_FMEM_LO0, OAS_FMEM_HI0) ||
                    in_range(op, OAS_FMEM_LO1, OAS_FMEM_HI1));
            end
            OAS_OC_PMEM: begin
               next_dec.bank = OAS_BANK_15;
               next_dec.addr = op;
               next_dec.unsupported =
                  !in_range(op, OAS_PMEM_LO, OAS_PMEM_HI);
            end
            OAS_OC_TADDR: begin
               next_dec.addr = op;
               next_dec.unsupported =
                  !in_range(op, OAS_TADDR_LO, OAS_TADDR_HI) ||
                  op[0];
            end
            OAS_OC_REL: begin
               next_dec.addr = op;
               next_dec.unsupported = !rel_ok(req_in.pc, op);
            end
            OAS_OC_CADDR: begin
               next_dec.addr = op;
            end
            OAS_OC_FADDR: begin
               next_dec.addr = op;
               next_dec.unsupported = (op > OAS_FADDR_HI);
            end
            default: begin
               next_dec.unsupported = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         dec_valid_out <= 1'b0;
         dec_out <= '0;
      end else begin
         dec_valid_out <= next_dec_valid;
         dec_out <= next_dec;
      end
   end

   // skip: the extra cycles fetch the next instruction but suppress it
   always_comb begin
      next_sk_state = sk_state;
      next_sk_cnt = sk_cnt;
      next_skip_extra = skip_extra_out;
      next_suppress = exec_suppress_out;
      case (sk_state)
         OAS_SK_IDLE: begin
            if (skip_go) begin
               if (skip_taken_in) begin
                  next_skip_extra = long_skip ? OAS_SKIP_LONG
                                              : OAS_SKIP_SHORT;
                  next_sk_cnt = next_skip_extra;
                  next_sk_state = OAS_SK_RUN;
                  next_suppress = 1'b1;
               end else begin
                  next_skip_extra = OAS_SKIP_NONE;
               end
            end
         end
         OAS_SK_RUN: begin
            if (ce_in && mc_tick_out) begin
               if (sk_cnt == OAS_SKIP_SHORT) begin
                  next_sk_state = OAS_SK_IDLE;
                  next_sk_cnt = OAS_SKIP_NONE;
                  next_suppress = 1'b0;
               end else begin
                  next_sk_cnt = sk_cnt - 2'h1;
               end
            end
         end
         default: begin
            next_sk_state = OAS_SK_IDLE;
            next_sk_cnt = OAS_SKIP_NONE;
            next_suppress = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         sk_state <= OAS_SK_IDLE;
         sk_cnt <= OAS_SKIP_NONE;
         skip_extra_out <= OAS_SKIP_NONE;
         exec_suppress_out <= 1'b0;
      end else if (ce_in) begin
         sk_state <= next_sk_state;
         sk_cnt <= next_sk_cnt;
         skip_extra_out <= next_skip_extra;
         exec_suppress_out <= next_suppress;
      end
   end

   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (rst_in);

   a_reg1_excl_acc: assert property (
      accept && req_in.opclass == OAS_OC_REG1 &&
      req_in.operand == 12'h001 |=> dec_out.unsupported)
      else $error("restricted register class took the accumulator");
   a_rp2_pair_set: assert property (
      accept && req_in.opclass == OAS_OC_RP2 &&
      req_in.operand == 12'h003 |=> dec_valid_out && dec_out.unsupported)
      else $error("two-pair class took HL");
   a_de_bank_zero: assert property (
      accept && req_in.operand == 12'h003 && (req_in.opclass == OAS_OC_RIP ||
      req_in.opclass == OAS_OC_RPA) |=> dec_out.addr[11:8] == OAS_BANK_0 &&
      dec_out.addr[7:0] == $past(ptr_in.de) && !dec_out.unsupported)
      else $error("DE access left bank 0");
   a_short_imm: assert property (
      accept && req_in.opclass == OAS_OC_N4 |=>
      dec_out.imm == {4'h0, $past(req_in.operand[3:0])})
      else $error("short immediate not 4 bits");
   a_io_bank_fixed: assert property (
      accept && (req_in.opclass == OAS_OC_FMEM ||
      req_in.opclass == OAS_OC_PMEM) |=> dec_out.bank == OAS_BANK_15)
      else $error("i/o operand left bank 15");
   a_pmem_range: assert property (
      accept && req_in.opclass == OAS_OC_PMEM &&
      req_in.operand == 12'hFBF |=> dec_out.unsupported)
      else $error("pointer-bit operand below FC0 accepted");
   a_taddr_even: assert property (
      accept && req_in.opclass == OAS_OC_TADDR && req_in.operand[0]
      |=> dec_out.unsupported)
      else $error("odd table vector accepted");
   a_direct_bank: assert property (
      accept && req_in.opclass == OAS_OC_MEM && !bank_enable_flag_in
      |=> dec_out.bank == ($past(req_in.operand[7]) ? OAS_BANK_15
                                                    : OAS_BANK_0))
      else $error("direct bank wrong with bank enable clear");
   a_hl_bank_and: assert property (
      accept && req_in.opclass == OAS_OC_RPA &&
      req_in.operand == 12'h000 |=> dec_out.bank ==
      ($past(bank_select_reg_in) & {4{$past(bank_enable_flag_in)}}))
      else $error("HL bank is not enable AND select");
   a_rel_reach: assert property (
      accept && req_in.opclass == OAS_OC_REL &&
      req_in.operand == req_in.pc + 12'h001 |=> dec_out.unsupported)
      else $error("relative target pc+1 accepted");
   a_skip_long: assert property (
      skip_go && skip_taken_in && long_skip |=>
      skip_extra_out == OAS_SKIP_LONG && exec_suppress_out)
      else $error("3-byte skip not charged two cycles");
   a_skip_no_exec: assert property (
      exec_suppress_out && ce_in |=> !dec_valid_out)
      else $error("decode issued during a skip");

   c_long_skip: cover property (skip_go && skip_taken_in && long_skip);
   c_hl_inc: cover property (accept && req_in.opclass == OAS_OC_RPA &&
                             req_in.operand == 12'h001);
   c_unsupported: cover property (dec_valid_out && dec_out.unsupported);

endmodule

// ---- src/oas_mc_timer.sv ----
// machine cycle timer: one tick per cpu clock period
// assumes the period setting comes from core logic on the same clock
`timescale 1ns/1ps
module oas_mc_timer import oas_pkg::*; #(
   parameter int DIV_0 = OAS_MC_DIV_0,
   parameter int DIV_1 = OAS_MC_DIV_1,
   parameter int DIV_2 = OAS_MC_DIV_2,
   parameter int DIV_3 = OAS_MC_DIV_3
) (
   // clock, reset, enable
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic ce_in,
   // period setting
   input wire logic [1:0] cpu_clock_ctrl_in,
   // tick
   output logic mc_tick_out
);

   logic [7:0] cnt;
   logic [7:0] next_cnt;
   logic next_tick;

   function automatic logic [7:0] last_count(input logic [1:0] sel);
      case (sel)
         2'h0: last_count = 8'(DIV_0 - 1);
         2'h1: last_count = 8'(DIV_1 - 1);
         2'h2: last_count = 8'(DIV_2 - 1);
         default: last_count = 8'(DIV_3 - 1);
      endcase
   endfunction

   // a change of setting takes effect at the next tick boundary or sooner
   always_comb begin
      next_cnt = cnt;
      next_tick = mc_tick_out;
      if (ce_in) begin
         if (cnt >= last_count(cpu_clock_ctrl_in)) begin
            next_cnt = 8'h00;
            next_tick = 1'b1;
         end else begin
            next_cnt = cnt + 8'h01;
            next_tick = 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         cnt <= 8'h00;
         mc_tick_out <= 1'b0;
      end else begin
         cnt <= next_cnt;
         mc_tick_out <= next_tick;
      end
   end

endmodule

// ---- tb/oas_decoder_tb_top.sv ----
// self-checking bench for the operand decoder and skip timing
// assumes default machine cycle dividers; ce_in held high except for a three-cycle low in the frozen-enable check
`timescale 1ns/1ps
module oas_decoder_tb_top import oas_pkg::*;;
   logic clk_sys_in = 1'h0;
   logic rst_in = 1'h1;
   logic bank_enable_flag = 1'h0;
   logic ce = 1'h1;
   logic req_valid = 1'h0;
   logic skip_valid = 1'h0;
   logic skip_taken = 1'h0;
   logic wr = 1'h0;
   logic [1:0] clk_ctrl = 2'h3;
   logic [3:0] bank_select_reg = 4'h0;
   oas_req_type req = '0;
   oas_ptr_type wr_data = '0;
   oas_ptr_type ptr;
   oas_skipop_type sop = OAS_SO_OTHER;
   logic dec_valid, mc_tick, suppress;
   oas_dec_type dec;
   logic [1:0] extra;
   int n_fail = 0;
   int checked = 0;

   always #2 clk_sys_in = ~clk_sys_in;

   oas_mem_model mem (.clk_sys_in(clk_sys_in), .wr_in(wr),
      .wr_data_in(wr_data), .ptr_out(ptr));

   oas_decoder uut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .ce_in(ce),
      .cpu_clock_ctrl_in(clk_ctrl), .bank_enable_flag_in(bank_enable_flag),
      .bank_select_reg_in(bank_select_reg), .req_valid_in(req_valid),
      .req_in(req),
      .ptr_in(ptr), .skip_valid_in(skip_valid), .skip_taken_in(skip_taken),
      .skipped_op_in(sop), .dec_valid_out(dec_valid), .dec_out(dec),
      .mc_tick_out(mc_tick), .exec_suppress_out(suppress),
      .skip_extra_out(extra));

   task automatic wrap_up();
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic cmp(input string what, input logic [11:0] exp,
                      input logic [11:0] got);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   // holds the request until the decoder can take it
   task automatic dec_chk(input oas_opclass_type oc, input logic [11:0] opd,
      input logic unsup, input logic [3:0] bank, input logic e = 1'h0,
      input logic [3:0] s = 4'h0, input logic [11:0] pc = 12'h100);
      int n;
      n = 0;
      @(negedge clk_sys_in);
      req = '{opclass: oc, operand: opd, pc: pc};
      bank_enable_flag = e;
      bank_select_reg = s;
      req_valid = 1'h1;
      while (!(mc_tick === 1'h1 && suppress === 1'h0) && n < 20) begin
         @(negedge clk_sys_in);
         n++;
      end
      @(negedge clk_sys_in);
      req_valid = 1'h0;
      cmp("dec_valid", 12'h001, 12'(dec_valid));
      cmp("unsupported", 12'(unsup), 12'(dec.unsupported));
      // bank is meaningless once the operand is refused
      if (!unsup) cmp("bank", 12'(bank), 12'(dec.bank));
   endtask

   // requests offered during suppression must be ignored
   task automatic skp(input logic tk, input oas_skipop_type op,
                      input logic [1:0] s);
      int n;
      logic seen;
      n = 0;
      seen = 1'h0;
      @(negedge clk_sys_in);
      skip_valid = 1'h1;
      skip_taken = tk;
      sop = op;
      @(negedge clk_sys_in);
      skip_valid = 1'h0;
      cmp("skip_extra", 12'(s), 12'(extra));
      while (suppress === 1'h1 && n < 10) begin
         req_valid = 1'h1;
         seen = seen | dec_valid;
         @(negedge clk_sys_in);
         n++;
      end
      req_valid = 1'h0;
      cmp("suppress_len", 12'(s), 12'(n));
      cmp("refused", 12'h000, 12'(seen | dec_valid));
      $display("skip test done op %0d", op);
   endtask

   task automatic tick_gap(input logic [1:0] setting, input int div);
      int n;
      @(negedge clk_sys_in);
      clk_ctrl = setting;
      for (int k = 0; k < 2; k++) begin
         n = 0;
         @(negedge clk_sys_in);
         while (mc_tick !== 1'h1 && n < 40) begin
            @(negedge clk_sys_in);
            n++;
         end
      end
      n = 0;
      do begin
         @(negedge clk_sys_in);
         n++;
      end while (mc_tick !== 1'h1 && n < 40);
      cmp("tick_gap", 12'(div), 12'(n));
   endtask

   initial begin
      repeat (10) @(negedge clk_sys_in);
      rst_in = 1'h0;
      tick_gap(2'h0, OAS_MC_DIV_0);
      tick_gap(2'h1, OAS_MC_DIV_1);
      tick_gap(2'h2, OAS_MC_DIV_2);
      tick_gap(2'h3, OAS_MC_DIV_3);
      $display("tick test done");
      // a request offered while the enable is low must not be taken
      @(negedge clk_sys_in);
      ce = 1'h0;
      req = '{opclass: OAS_OC_N4, operand: 12'h005, pc: 12'h100};
      req_valid = 1'h1;
      repeat (3) @(negedge clk_sys_in);
      cmp("frozen_valid", 12'h000, 12'(dec_valid));
      ce = 1'h1;
      req_valid = 1'h0;
      @(negedge clk_sys_in);
      wr_data = '{hl: 8'h3C, de: 8'h12, dl: 8'h34};
      wr = 1'h1;
      @(negedge clk_sys_in);
      wr = 1'h0;
      dec_chk(OAS_OC_REG, 12'(OAS_REG_A), 1'h0, 4'h0);
      dec_chk(OAS_OC_REG1, 12'(OAS_REG_A), 1'h1, 4'h0);
      dec_chk(OAS_OC_REG1, 12'h000, 1'h0, 4'h0);
      dec_chk(OAS_OC_RP, 12'(OAS_RP_XA), 1'h0, 4'h0);
      dec_chk(OAS_OC_RP1, 12'(OAS_RP_XA), 1'h1, 4'h0);
      dec_chk(OAS_OC_RP2, 12'(OAS_RP_DE), 1'h0, 4'h0);
      dec_chk(OAS_OC_RP2, 12'h003, 1'h1, 4'h0);
      dec_chk(OAS_OC_RPX1, 12'h000, 1'h1, 4'h0);
      dec_chk(OAS_OC_RP2, 12'(OAS_RP_BC), 1'h0, 4'h0);
      dec_chk(OAS_OC_RPX, 12'h004, 1'h0, 4'h0);
      dec_chk(OAS_OC_RPA, 12'(OAS_PA_HL), 1'h0, 4'h4, 1'h1, 4'h4);
      cmp("addr", 12'h43C, dec.addr);
      dec_chk(OAS_OC_RPA, 12'(OAS_PA_HL), 1'h0, 4'h0, 1'h0, 4'hF);
      dec_chk(OAS_OC_RPA, 12'(OAS_PA_DE), 1'h0, 4'h0, 1'h1, 4'hF);
      cmp("addr", 12'h012, dec.addr);
      dec_chk(OAS_OC_RIP, 12'(OAS_PA_HL), 1'h1, 4'h0);
      dec_chk(OAS_OC_RIP, 12'(OAS_PA_DL), 1'h0, 4'h0, 1'h1, 4'h4);
      cmp("addr", 12'h034, dec.addr);
      dec_chk(OAS_OC_N4, 12'h00F, 1'h0, 4'h0);
      dec_chk(OAS_OC_N4, 12'h010, 1'h1, 4'h0);
      dec_chk(OAS_OC_N8, 12'h0FF, 1'h0, 4'h0);
      dec_chk(OAS_OC_N8, 12'h100, 1'h1, 4'h0);
      dec_chk(OAS_OC_MEM, 12'h07F, 1'h0, 4'h0);
      dec_chk(OAS_OC_MEM, 12'h080, 1'h0, 4'hF);
      dec_chk(OAS_OC_MEM, 12'h080, 1'h0, 4'h4, 1'h1, 4'h4);
      cmp("addr", 12'h480, dec.addr);
      dec_chk(OAS_OC_MEM8, 12'h080, 1'h0, 4'hF);
      dec_chk(OAS_OC_MEM8, 12'h081, 1'h1, 4'h0);
      dec_chk(OAS_OC_BIT, 12'h003, 1'h0, 4'h0);
      dec_chk(OAS_OC_BIT, 12'h004, 1'h1, 4'h0);
      dec_chk(OAS_OC_FMEM, 12'hFBF, 1'h0, 4'hF, 1'h1, 4'h0);
      dec_chk(OAS_OC_FMEM, 12'hFF0, 1'h0, 4'hF, 1'h1, 4'h4);
      dec_chk(OAS_OC_FMEM, 12'hFC0, 1'h1, 4'h0);
      dec_chk(OAS_OC_FMEM, 12'hFAF, 1'h1, 4'h0);
      dec_chk(OAS_OC_PMEM, 12'hFC0, 1'h0, 4'hF, 1'h1, 4'h0);
      dec_chk(OAS_OC_PMEM, 12'hFBF, 1'h1, 4'h0);
      dec_chk(OAS_OC_TADDR, 12'h020, 1'h0, 4'h0);
      dec_chk(OAS_OC_TADDR, 12'h07E, 1'h0, 4'h0);
      dec_chk(OAS_OC_TADDR, 12'h021, 1'h1, 4'h0);
      dec_chk(OAS_OC_TADDR, 12'h080, 1'h1, 4'h0);
      dec_chk(OAS_OC_TADDR, 12'h01E, 1'h1, 4'h0);
      dec_chk(OAS_OC_REL, 12'h0F1, 1'h0, 4'h0);
      dec_chk(OAS_OC_REL, 12'h0F0, 1'h1, 4'h0);
      dec_chk(OAS_OC_REL, 12'h101, 1'h1, 4'h0);
      dec_chk(OAS_OC_REL, 12'h102, 1'h0, 4'h0);
      dec_chk(OAS_OC_REL, 12'h110, 1'h0, 4'h0);
      dec_chk(OAS_OC_REL, 12'h111, 1'h1, 4'h0);
      dec_chk(OAS_OC_CADDR, 12'hFFF, 1'h0, 4'h0);
      dec_chk(OAS_OC_FADDR, 12'h7FF, 1'h0, 4'h0);
      dec_chk(OAS_OC_FADDR, 12'h800, 1'h1, 4'h0);
      $display("decode test done");
      // taken skip first, so the not-taken one must clear a non-zero count
      skp(1'h1, OAS_SO_OTHER, OAS_SKIP_SHORT);
      skp(1'h0, OAS_SO_BR_ABS, OAS_SKIP_NONE);
      for (int k = 1; k < 5; k++) begin
         skp(1'h1, oas_skipop_type'(k), OAS_SKIP_LONG);
      end
      wrap_up();
   end

   initial begin
      repeat (5000) @(posedge clk_sys_in);
      n_fail++;
      $display("mismatch watchdog expected done seen hang");
      wrap_up();
   end
endmodule

// ---- tb/oas_mem_model.sv ----
// pointer register store standing in for the core's data side
// assumes the bench writes it off the rising edge of clk_sys_in
`timescale 1ns/1ps
module oas_mem_model import oas_pkg::*; (
   // clock
   input wire logic clk_sys_in,
   // write side
   input wire logic wr_in,
   input wire oas_ptr_type wr_data_in,
   // pointer contents
   output oas_ptr_type ptr_out
);
   // starts from a non-zero pattern so a stale zero cannot pass
   initial ptr_out = '{hl: 8'hA5, de: 8'h5A, dl: 8'hC3};
   always @(posedge clk_sys_in) begin
      if (wr_in) begin
         ptr_out <= wr_data_in;
      end
   end
endmodule
